// ==== uea_pkg.sv ====
package uea_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int EP_N = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_TX_EVENT = 4'h0;
  localparam logic [3:0] OFS_TX_MASK = 4'h1;
  localparam logic [3:0] OFS_RX_EVENT = 4'h2;
  localparam logic [3:0] OFS_RX_MASK = 4'h3;
  localparam logic [3:0] OFS_REFUSAL_EVENT = 4'h4;
  localparam logic [3:0] OFS_REFUSAL_MASK = 4'h5;
  localparam logic [3:0] OFS_THRESH_EVENT = 4'h6;
  localparam logic [3:0] OFS_THRESH_MASK = 4'h7;
  localparam logic [3:0] OFS_MAIN_MASK = 4'h8;
  localparam logic [3:0] OFS_MAIN_EVENT = 4'h9;

  // ----------------------------------------------------------------
  // main event register bit positions
  // ----------------------------------------------------------------
  localparam int MAIN_WARN_BIT = 0;
  localparam int MAIN_TX_BIT = 2;
  localparam int MAIN_NAK_BIT = 4;
  localparam int MAIN_RX_BIT = 6;
  localparam int MAIN_INTR_BIT = 7;

  // ----------------------------------------------------------------
  // per-endpoint enables of optional flags (endpoint 0 excluded)
  // ----------------------------------------------------------------
  localparam logic [3:0] URUN_EP_MASK = 4'hE;
  localparam logic [3:0] RX_ERR_EP_MASK = 4'hE;
  localparam logic [3:0] WARN_EP_MASK = 4'hE;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [3:0] RST_FLAG4 = 4'h0;

endpackage

// ==== uea_top.sv ====
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps

// Behaviour
// - transmit-complete flag per endpoint in bits 3..0, set when IN finishes
// - transmit-complete flag clears on its endpoint's transmit status read
// - transmit-underrun flag per endpoint, bits 7..4, set on FIFO underflow
// - transmit-underrun flag clears on its endpoint's transmit status read
// - endpoint 0 transmit-underrun flag always reads zero
// - transmit summary set while any unmasked transmit flag is set
// - receive-complete flag per endpoint set on receive error or last byte
// - receive-complete flag clears on its endpoint's receive status read
// - endpoint 0 receive-complete follows only its last-byte status
// - receive-overrun flags, bits 7..4, all clear on receive event read
// - receive summary set while any unmasked receive flag is set
// - IN refusal flag set on IN NAK when address and endpoint enabled
// - OUT refusal flag set on OUT NAK when enabled, not on overrun NAK
// - refusal flags clear when the refusal event register is read
// - refusal summary set while any unmasked refusal flag is set
// - transmit threshold flags 3..1 set at threshold while transmit enabled
// - transmit threshold flag clears on FIFO write, flush or transmit done
// - receive threshold flag bits 7..5 set at threshold, bit 4 reserved
// - receive threshold flag clears on FIFO read or flush
// - threshold summary set while any unmasked threshold flag is set
// - threshold summary is main bit 0, cleared by reading threshold events
// - main mask bit 7 is master enable; main event bit 7 reads zero
module uea_top
  import uea_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [DATA_W-1:0] rd_data_out,
  // transmit side events
  input wire logic [EP_N-1:0] tx_done_in,
  input wire logic [EP_N-1:0] tx_underflow_in,
  input wire logic [EP_N-1:0] tx_status_read_in,
  // receive side events
  input wire logic [EP_N-1:0] rx_last_in,
  input wire logic [EP_N-1:0] rx_error_in,
  input wire logic [EP_N-1:0] rx_overflow_in,
  input wire logic [EP_N-1:0] rx_status_read_in,
  // handshake refusal events
  input wire logic function_address_enable_in,
  input wire logic [EP_N-1:0] in_endpoint_enable_in,
  input wire logic [EP_N-1:0] out_endpoint_enable_in,
  input wire logic [EP_N-1:0] in_nak_in,
  input wire logic [EP_N-1:0] out_nak_in,
  input wire logic [EP_N-1:0] out_nak_overrun_in,
  // FIFO threshold events
  input wire logic [EP_N-1:0] tx_threshold_reached_in,
  input wire logic [EP_N-1:0] tx_enable_in,
  input wire logic [EP_N-1:0] tx_fifo_write_in,
  input wire logic [EP_N-1:0] tx_fifo_flush_in,
  input wire logic [EP_N-1:0] rx_threshold_reached_in,
  input wire logic [EP_N-1:0] rx_fifo_read_in,
  input wire logic [EP_N-1:0] rx_fifo_flush_in,
  // summary towards the main event logic
  output logic [DATA_W-1:0] main_event_out,
  output logic master_enable_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_sync1;
  logic rst_n;

  // assertion is immediate, release waits two edges to avoid metastability
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] transmit_complete_flags;
  logic [3:0] transmit_underflow_flags;
  logic [3:0] receive_complete_flags;
  logic [3:0] receive_overflow_flags;
  logic [3:0] in_refusal_flags;
  logic [3:0] out_refusal_flags;
  logic [3:0] transmit_threshold_flags;
  logic [3:0] receive_threshold_flags;
  logic [7:0] transmit_mask_reg;
  logic [7:0] receive_mask_reg;
  logic [7:0] refusal_mask_reg;
  logic [7:0] threshold_mask_reg;
  logic [7:0] main_mask_reg;
  logic warn_summary;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire rd_tx_event = rd_strobe_in && (addr_in == OFS_TX_EVENT);
  wire rd_rx_event = rd_strobe_in && (addr_in == OFS_RX_EVENT);
  wire rd_refusal = rd_strobe_in && (addr_in == OFS_REFUSAL_EVENT);
  wire rd_threshold = rd_strobe_in && (addr_in == OFS_THRESH_EVENT);
  wire wr_tx_mask = wr_strobe_in && (addr_in == OFS_TX_MASK);
  wire wr_rx_mask = wr_strobe_in && (addr_in == OFS_RX_MASK);
  wire wr_refusal_mask = wr_strobe_in && (addr_in == OFS_REFUSAL_MASK);
  wire wr_threshold_mask = wr_strobe_in && (addr_in == OFS_THRESH_MASK);
  wire wr_main_mask = wr_strobe_in && (addr_in == OFS_MAIN_MASK);

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  wire [7:0] transmit_event_reg = {transmit_underflow_flags,
                                   transmit_complete_flags};
  wire [7:0] receive_event_reg = {receive_overflow_flags,
                                  receive_complete_flags};
  wire [7:0] refusal_event_reg = {out_refusal_flags, in_refusal_flags};
  wire [7:0] threshold_event_reg = {receive_threshold_flags,
                                    transmit_threshold_flags};

  // ----------------------------------------------------------------
  // flag next values; every set term is ORed after the clear
  // ----------------------------------------------------------------
  // a set in the clear cycle survives, so no event is lost
  wire [3:0] next_transmit_complete = tx_done_in |
    (transmit_complete_flags & ~tx_status_read_in);
  wire [3:0] next_transmit_underflow = (tx_underflow_in & URUN_EP_MASK) |
    (transmit_underflow_flags & ~tx_status_read_in);
  // endpoint 0 drops errored packets, so only last byte counts there
  wire [3:0] rx_complete_set = rx_last_in |
    (rx_error_in & RX_ERR_EP_MASK);
  wire [3:0] next_receive_complete = rx_complete_set |
    (receive_complete_flags & ~rx_status_read_in);
  wire [3:0] next_receive_overflow = rx_overflow_in |
    (receive_overflow_flags & ~{4{rd_rx_event}});
  wire [3:0] in_gate = {4{function_address_enable_in}} &
    in_endpoint_enable_in;
  wire [3:0] out_gate = {4{function_address_enable_in}} &
    out_endpoint_enable_in;
  wire [3:0] next_in_refusal = (in_nak_in & in_gate) |
    (in_refusal_flags & ~{4{rd_refusal}});
  wire [3:0] next_out_refusal = (out_nak_in & ~out_nak_overrun_in &
    out_gate) | (out_refusal_flags & ~{4{rd_refusal}});
  // threshold flags follow the FIFO condition, not software reads
  wire [3:0] tx_warn_end = tx_fifo_write_in | tx_fifo_flush_in | tx_done_in;
  wire [3:0] next_transmit_threshold = ((tx_threshold_reached_in &
    tx_enable_in) | (transmit_threshold_flags & ~tx_warn_end)) &
    WARN_EP_MASK;
  wire [3:0] rx_warn_end = rx_fifo_read_in | rx_fifo_flush_in;
  wire [3:0] next_receive_threshold = (rx_threshold_reached_in |
    (receive_threshold_flags & ~rx_warn_end)) & WARN_EP_MASK;

  // ----------------------------------------------------------------
  // summaries
  // ----------------------------------------------------------------
  // summaries track the flags just stored, hence one cycle behind them
  wire tx_hit = |(transmit_event_reg & transmit_mask_reg);
  wire rx_hit = |(receive_event_reg & receive_mask_reg);
  wire nak_hit = |(refusal_event_reg & refusal_mask_reg);
  wire warn_hit = |(threshold_event_reg & threshold_mask_reg);
  // warning summary is sticky until the threshold events are read
  wire next_warn_summary = warn_hit |
    (warn_summary & ~rd_threshold);
  wire [7:0] next_main_event = {1'b0, rx_hit, 1'b0, nak_hit, 1'b0,
    tx_hit, 1'b0, next_warn_summary};

  // ----------------------------------------------------------------
  // read mux; unmapped offsets read zero
  // ----------------------------------------------------------------
  wire [7:0] rd_mux =
    (addr_in == OFS_TX_EVENT) ? transmit_event_reg :
    (addr_in == OFS_TX_MASK) ? transmit_mask_reg :
    (addr_in == OFS_RX_EVENT) ? receive_event_reg :
    (addr_in == OFS_RX_MASK) ? receive_mask_reg :
    (addr_in == OFS_REFUSAL_EVENT) ? refusal_event_reg :
    (addr_in == OFS_REFUSAL_MASK) ? refusal_mask_reg :
    (addr_in == OFS_THRESH_EVENT) ? threshold_event_reg :
    (addr_in == OFS_THRESH_MASK) ? threshold_mask_reg :
    (addr_in == OFS_MAIN_MASK) ? main_mask_reg :
    (addr_in == OFS_MAIN_EVENT) ? main_event_out :
    RST_REG8;

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  // read data captures the old value at the same edge the clear lands
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      transmit_complete_flags <= RST_FLAG4;
      transmit_underflow_flags <= RST_FLAG4;
      receive_complete_flags <= RST_FLAG4;
      receive_overflow_flags <= RST_FLAG4;
      in_refusal_flags <= RST_FLAG4;
      out_refusal_flags <= RST_FLAG4;
      transmit_threshold_flags <= RST_FLAG4;
      receive_threshold_flags <= RST_FLAG4;
    end else begin
      transmit_complete_flags <= next_transmit_complete;
      transmit_underflow_flags <= next_transmit_underflow;
      receive_complete_flags <= next_receive_complete;
      receive_overflow_flags <= next_receive_overflow;
      in_refusal_flags <= next_in_refusal;
      out_refusal_flags <= next_out_refusal;
      transmit_threshold_flags <= next_transmit_threshold;
      receive_threshold_flags <= next_receive_threshold;
    end
  end

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      transmit_mask_reg <= RST_REG8;
      receive_mask_reg <= RST_REG8;
      refusal_mask_reg <= RST_REG8;
      threshold_mask_reg <= RST_REG8;
      main_mask_reg <= RST_REG8;
    end else begin
      if (wr_tx_mask) transmit_mask_reg <= wr_data_in;
      if (wr_rx_mask) receive_mask_reg <= wr_data_in;
      if (wr_refusal_mask) refusal_mask_reg <= wr_data_in;
      if (wr_threshold_mask) threshold_mask_reg <= wr_data_in;
      if (wr_main_mask) main_mask_reg <= wr_data_in;
    end
  end

  // master enable copied from the mask so the output is a flop
  wire next_master_enable = wr_main_mask ? wr_data_in[MAIN_INTR_BIT] :
    main_mask_reg[MAIN_INTR_BIT];

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // read data stands for exactly one cycle, zero otherwise
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_out <= RST_REG8;
      main_event_out <= RST_REG8;
      warn_summary <= 1'b0;
      master_enable_out <= 1'b0;
    end else begin
      rd_data_out <= rd_strobe_in ? rd_mux : RST_REG8;
      main_event_out <= next_main_event;
      warn_summary <= next_warn_summary;
      master_enable_out <= next_master_enable;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_tx_event_read;
    rd_tx_event;
  endsequence

  sequence s_main_event_read;
    rd_strobe_in && addr_in == OFS_MAIN_EVENT;
  endsequence

  a_tx_done_sets: assert property (
    tx_done_in[2] |=> transmit_complete_flags[2])
    else $error("transmit complete not set");

  a_tx_read_clears: assert property (
    tx_status_read_in[1] && !tx_done_in[1] |=> !transmit_complete_flags[1])
    else $error("transmit complete not cleared by status read");

  a_urun_sets: assert property (
    tx_underflow_in[3] |=> transmit_underflow_flags[3] ##0
      (!tx_status_read_in[3] || tx_underflow_in[3]) [*1] ##1
      transmit_underflow_flags[3])
    else $error("underrun flag lost");

  a_urun_ep0_zero: assert property (
    s_tx_event_read ##0 tx_underflow_in[0] |=> rd_data_out[4] == 1'b0)
    else $error("endpoint 0 underrun read nonzero");

  a_tx_summary: assert property (
    (|(transmit_event_reg & transmit_mask_reg)) |=>
      main_event_out[MAIN_TX_BIT])
    else $error("transmit summary missing");

  a_tx_mask_blocks: assert property (
    transmit_mask_reg == 8'h00 |=> !main_event_out[MAIN_TX_BIT])
    else $error("masked transmit flag reached summary");

  a_rx0_error_only: assert property (
    rx_error_in[0] && !rx_last_in[0] && !receive_complete_flags[0]
      |=> !receive_complete_flags[0])
    else $error("endpoint 0 error set receive complete");

  a_rx_err_sets: assert property (
    rx_error_in[2] |=> receive_complete_flags[2])
    else $error("receive error did not set flag");

  a_overrun_read: assert property (
    rd_rx_event && rx_overflow_in == 4'h0 |=> receive_overflow_flags == 4'h0)
    else $error("overrun flags survived read");

  a_set_beats_clear: assert property (
    rd_rx_event && rx_overflow_in[1] |=> receive_overflow_flags[1])
    else $error("same-cycle overrun lost to clear");

  a_in_nak_gate: assert property (
    in_nak_in[0] && !function_address_enable_in && !in_refusal_flags[0]
      |=> !in_refusal_flags[0])
    else $error("IN refusal set while address disabled");

  a_out_nak_overrun: assert property (
    out_nak_in[1] && out_nak_overrun_in[1] && !out_refusal_flags[1]
      |=> !out_refusal_flags[1])
    else $error("OUT refusal set by overrun");

  a_refusal_read: assert property (
    rd_refusal && in_nak_in == 4'h0 && out_nak_in == 4'h0
      |=> refusal_event_reg == 8'h00)
    else $error("refusal flags survived read");

  a_tx_warn_end: assert property (
    tx_fifo_flush_in[2] && !tx_threshold_reached_in[2]
      |=> !transmit_threshold_flags[2])
    else $error("transmit threshold flag not cleared");

  a_warn_reserved: assert property (
    rd_threshold |=> rd_data_out[4] == 1'b0 && rd_data_out[0] == 1'b0)
    else $error("reserved threshold bit set");

  a_warn_sticky: assert property (
    warn_summary && !rd_threshold |=> warn_summary [*1])
    else $error("threshold summary dropped without read");

  a_intr_zero: assert property (
    s_main_event_read |=> rd_data_out[MAIN_INTR_BIT] == 1'b0)
    else $error("main event bit 7 read nonzero");

  a_read_once: assert property (
    !rd_strobe_in |=> rd_data_out == 8'h00)
    else $error("read data outside its cycle");

  a_rx_summary: assert property (
    (|(receive_event_reg & receive_mask_reg)) |=>
      main_event_out[MAIN_RX_BIT])
    else $error("receive summary missing");

  a_nak_summary: assert property (
    (|(refusal_event_reg & refusal_mask_reg)) |=>
      main_event_out[MAIN_NAK_BIT])
    else $error("refusal summary missing");

  a_warn_summary: assert property (
    (|(threshold_event_reg & threshold_mask_reg)) |=>
      main_event_out[MAIN_WARN_BIT])
    else $error("threshold summary missing");

  a_rx_warn_end: assert property (
    rx_fifo_read_in[1] && !rx_threshold_reached_in[1]
      |=> !receive_threshold_flags[1])
    else $error("receive threshold flag not cleared");

endmodule

// ==== uea_fw_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// firmware model: single-cycle accesses on the host register port
// ----------------------------------------------------------------
module uea_fw_model
  import uea_pkg::*;
(
  input wire logic mclk_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wr_data_out,
  output logic wr_strobe_out,
  output logic rd_strobe_out,
  input wire logic [DATA_W-1:0] rd_data_in
);
  // idle bus from time zero
  initial begin
    addr_out = 4'h0;
    wr_data_out = 8'h00;
    wr_strobe_out = 1'b0;
    rd_strobe_out = 1'b0;
  end

  // one write cycle; data is inverted afterwards so stale data never
  // looks like a valid write
  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_strobe_out <= 1'b1;
    @(posedge mclk_in);
    wr_strobe_out <= 1'b0;
    wr_data_out <= ~d;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    rd_strobe_out <= 1'b1;
    @(posedge mclk_in);
    rd_strobe_out <= 1'b0;
    #1;
    d = rd_data_in;
  endtask
endmodule

// ==== uea_top_test.sv ====
`timescale 1ns/10ps

module uea_top_test
  import uea_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_strobe;
  logic rd_strobe;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] main_event;
  logic master_enable;
  // event pulses: 0 tx done, 1 underflow, 2 tx status read, 3 rx last,
  // 4 rx error, 5 rx overflow, 6 rx status read, 7 in nak, 8 out nak,
  // 9 tx threshold, 10 tx write, 11 tx flush, 12 rx threshold,
  // 13 rx read, 14 rx flush
  logic [EP_N-1:0] evs [15] = '{default: 4'h0};
  logic fae = 1'b0;
  logic [EP_N-1:0] in_en = 4'h0;
  logic [EP_N-1:0] out_en = 4'h0;
  logic [EP_N-1:0] nak_ovr = 4'h0;
  logic [EP_N-1:0] tx_en = 4'h0;
  logic [7:0] got;
  logic [3:0] m_ofs [5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h8};
  logic [7:0] m_val [5] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h81};
  int mismatches = 0;
  int n_compared = 0;

  // 100 MHz clock
  always #5 mclk_in = ~mclk_in;

  uea_top u_uea_top (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr),
    .wr_data_in(wr_data), .wr_strobe_in(wr_strobe),
    .rd_strobe_in(rd_strobe), .rd_data_out(rd_data),
    .tx_done_in(evs[0]), .tx_underflow_in(evs[1]),
    .tx_status_read_in(evs[2]), .rx_last_in(evs[3]),
    .rx_error_in(evs[4]), .rx_overflow_in(evs[5]),
    .rx_status_read_in(evs[6]), .function_address_enable_in(fae),
    .in_endpoint_enable_in(in_en), .out_endpoint_enable_in(out_en),
    .in_nak_in(evs[7]), .out_nak_in(evs[8]),
    .out_nak_overrun_in(nak_ovr), .tx_threshold_reached_in(evs[9]),
    .tx_enable_in(tx_en), .tx_fifo_write_in(evs[10]),
    .tx_fifo_flush_in(evs[11]), .rx_threshold_reached_in(evs[12]),
    .rx_fifo_read_in(evs[13]), .rx_fifo_flush_in(evs[14]),
    .main_event_out(main_event), .master_enable_out(master_enable)
  );

  uea_fw_model u_uea_fw_model (
    .mclk_in(mclk_in), .addr_out(addr), .wr_data_out(wr_data),
    .wr_strobe_out(wr_strobe), .rd_strobe_out(rd_strobe),
    .rd_data_in(rd_data)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    u_uea_fw_model.bus_read(a, got);
    chk(got, e);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_uea_fw_model.bus_write(a, d);
  endtask

  // one-cycle pulse, then room for flag and summary to settle
  task automatic ev(input int k, input logic [3:0] v);
    @(posedge mclk_in);
    evs[k] <= v;
    @(posedge mclk_in);
    evs[k] <= 4'h0;
    repeat (3) @(posedge mclk_in);
  endtask

  // summary lags its cause by two cycles
  task automatic me(input logic [7:0] e);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(main_event, e);
  endtask

  task print_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    // every offset, unmapped ones included, reads zero after reset
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), 8'h00);
    end
    // masks are read/write; event and main event writes are ignored
    for (int i = 0; i < 5; i++) begin
      wr(m_ofs[i], m_val[i]);
    end
    wr(OFS_TX_EVENT, 8'hFF);
    wr(OFS_MAIN_EVENT, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      rd(m_ofs[i], m_val[i]);
    end
    rd(OFS_TX_EVENT, 8'h00);
    rd(OFS_MAIN_EVENT, 8'h00);
    chk({7'h00, master_enable}, 8'h01);
    wr(OFS_MAIN_MASK, 8'h7F);
    me(8'h00);
    chk({7'h00, master_enable}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(m_ofs[i], 8'h00);
    end
    // transmit completion and underflow; endpoint 0 never underflows
    ev(0, 4'hF);
    ev(1, 4'hF);
    rd(OFS_TX_EVENT, 8'hEF);
    me(8'h00);
    wr(OFS_TX_MASK, 8'h02);
    me(8'h04);
    wr(OFS_TX_MASK, 8'h20);
    ev(2, 4'h2);
    rd(OFS_TX_EVENT, 8'hCD);
    me(8'h00);
    ev(2, 4'hF);
    rd(OFS_TX_EVENT, 8'h00);
    // receive: endpoint 0 ignores errors, streaming endpoint shows them
    wr(OFS_RX_MASK, 8'h10);
    ev(4, 4'h5);
    rd(OFS_RX_EVENT, 8'h04);
    ev(3, 4'h1);
    ev(5, 4'h1);
    me(8'h40);
    rd(OFS_RX_EVENT, 8'h15);
    rd(OFS_RX_EVENT, 8'h05);
    me(8'h00);
    ev(6, 4'h4);
    rd(OFS_RX_EVENT, 8'h01);
    ev(6, 4'h1);
    // overflow in the very cycle of the clearing read survives it
    fork
      rd(OFS_RX_EVENT, 8'h00);
      begin
        @(posedge mclk_in);
        evs[5] <= 4'h8;
        @(posedge mclk_in);
        evs[5] <= 4'h0;
      end
    join
    rd(OFS_RX_EVENT, 8'h80);
    rd(OFS_RX_EVENT, 8'h00);
    // refusals: endpoint disable, address disable, overrun qualifier
    @(posedge mclk_in);
    fae <= 1'b1;
    in_en <= 4'hB;
    out_en <= 4'hD;
    ev(7, 4'hF);
    @(posedge mclk_in);
    nak_ovr <= 4'h4;
    ev(8, 4'hE);
    nak_ovr <= 4'h0;
    fae <= 1'b0;
    in_en <= 4'hF;
    ev(7, 4'h4);
    wr(OFS_REFUSAL_MASK, 8'h80);
    me(8'h10);
    rd(OFS_REFUSAL_EVENT, 8'h8B);
    rd(OFS_REFUSAL_EVENT, 8'h00);
    me(8'h00);
    // thresholds: gated transmit, reserved bit 4, each clearing cause
    @(posedge mclk_in);
    tx_en <= 4'h6;
    ev(9, 4'hF);
    ev(12, 4'hF);
    rd(OFS_THRESH_EVENT, 8'hE6);
    wr(OFS_THRESH_MASK, 8'h02);
    me(8'h01);
    ev(10, 4'h2);
    ev(0, 4'h4);
    rd(OFS_THRESH_EVENT, 8'hE0);
    ev(13, 4'h2);
    ev(14, 4'hC);
    rd(OFS_THRESH_EVENT, 8'h00);
    ev(9, 4'h2);
    ev(11, 4'h2);
    rd(OFS_THRESH_EVENT, 8'h00);
    me(8'h00);
    // mid-run reset must wipe the flag and masks still set above
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd(OFS_TX_EVENT, 8'h00);
    rd(OFS_TX_MASK, 8'h00);
    rd(OFS_THRESH_MASK, 8'h00);
    rd(OFS_MAIN_MASK, 8'h00);
    print_verdict;
  end
endmodule
